// ==== mpa_top.sv ====
// mpa_top: three-phase pwm with fault stop, master reload, converter trigger sequencer
// and slow-loop timer, all on one clock, registers over classic wishbone
// assumes synchronous inputs, converters answer each start with one done pulse
//
// Functional notes
// - master reload on every nth reload opportunity
// - followers use master tick, resync on reload
// - master trigger at first compare after reload
// - trigger delayed by half the dead time
// - fault stops all six outputs, self-clearing
// - outputs return at first reload after fault
// - period runs from start value to period compare
// - dead time set in nanoseconds, on pairs
// - six outputs, two per phase submodule
// - separate trigger chain per converter
// - two entries per chain, back to back
// - shared setting starts both from master trigger
// - fast interrupt after every active converter chain finishes
// - crossbar routes master trigger to input zero
// - slow timer compare is clock over sixteen times rate
// - slow interrupt at each compare reload
`timescale 1ns/1ps
`default_nettype none
module mpa_top #(
  parameter int RES_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fault_i,
  output logic [5:0] pwm_o,
  output logic master_trigger_o,
  output logic [1:0] conv_start_o,
  output logic [3:0] conv_chan1_o,
  output logic [3:0] conv_chan2_o,
  input wire logic [1:0] conv_done_i,
  input wire logic [RES_W-1:0] conv_data1_i,
  input wire logic [RES_W-1:0] conv_data2_i,
  output logic fast_loop_irq_o,
  output logic slow_loop_irq_o
);
  import mpa_pkg::*;

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // nanoseconds to whole clock cycles, rounded up
  function automatic logic [15:0] ns_to_cycles(input logic [15:0] ns);
    logic [31:0] p;
    p = 32'(ns) * 32'(CLK_MHZ) + 32'h0000_03E7;
    return 16'(p / 32'h0000_03E8);
  endfunction

  // software registers
  logic [3:0] ctrl_reg;
  logic [7:0] skip_reg;
  logic [15:0] init_reg;
  logic [15:0] period_reg;
  logic [15:0] trig_reg;
  logic [15:0] dead_reg;
  logic [15:0] duty_reg [3];
  logic [15:0] duty_sh_reg [3];
  logic [15:0] slow_cmp_reg;
  logic [15:0] chain_reg;
  logic [31:0] rd_reg;
  logic ack_reg;

  // pwm state
  logic [7:0] skip_cnt_reg;
  logic fault_reg;
  logic armed_reg;
  logic mtrig_reg;
  logic [5:0] pwm_reg;

  // sequencer state
  mpa_seq_t sq_reg [2];
  logic [1:0] start_reg;
  logic [3:0] chan_reg [2];
  logic [RES_W-1:0] res_reg [2][2];
  logic fast_irq_reg;

  // slow timer state
  logic [3:0] pre_reg;
  logic [15:0] slow_cnt_reg;
  logic slow_irq_reg;

  // phase submodules, 0 is the master
  mpa_phase_if #(.W(16)) ph [3] ();
  for (genvar g = 0; g < 3; g++) begin : g_ph
    mpa_phase u_phase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pif(ph[g])
    );
  end

  // configuration decode
  wire run = ctrl_reg[CTRL_RUN_BIT];
  wire sync_mode = ctrl_reg[CTRL_SYNC_BIT]; // shared_trigger_setting
  wire [1:0] xbar_sel = ctrl_reg[CTRL_XBAR_LSB +: 2];
  wire [15:0] dt_cyc = ns_to_cycles(dead_reg);
  wire [7:0] skip_eff = (skip_reg == 8'h00) ? 8'h01 : skip_reg;

  // reload opportunity and master reload
  wire m_wrap = ph[0].wrap;
  wire skip_last = (skip_cnt_reg >= 8'(skip_eff - 8'h01));
  wire master_reload = m_wrap && skip_last;

  // trigger point shifted by half the dead time
  wire [15:0] trig_point = 16'(trig_reg + {1'b0, dt_cyc[15:1]});
  wire trig_hit = armed_reg && ph[0].tick && (ph[0].cnt == signed'(trig_point));

  // fault gating holds outputs off while latched or active
  wire out_en = run && !fault_reg && !fault_i;

  // phase wiring: master tick drives the followers
  assign ph[0].cnt_en = run;
  assign ph[1].cnt_en = ph[0].tick;
  assign ph[2].cnt_en = ph[0].tick;
  assign ph[0].sync = master_reload;
  assign ph[1].sync = master_reload;
  assign ph[2].sync = master_reload;
  for (genvar g = 0; g < 3; g++) begin : g_cfg
    assign ph[g].out_en = out_en;
    assign ph[g].init = signed'(init_reg);
    assign ph[g].period = signed'(period_reg);
    assign ph[g].duty = signed'(duty_sh_reg[g]);
    assign ph[g].dt_cycles = dt_cyc;
  end

  // crossbar: source of sequencer input zero
  wire seq_in0 = (xbar_sel == MPA_XB_MASTER) ? trig_hit :
                 (xbar_sel == MPA_XB_FOL1) ? ph[1].wrap :
                 (xbar_sel == MPA_XB_FOL2) ? ph[2].wrap : 1'b0;

  // chain activity and completion
  wire [1:0] active = {sync_mode, 1'b1};
  wire [1:0] chain_done;
  assign chain_done[0] = (sq_reg[0] == MPA_SQ_DONE);
  assign chain_done[1] = !active[1] || (sq_reg[1] == MPA_SQ_DONE);
  wire all_done = &chain_done;
  wire [RES_W-1:0] conv_data [2];
  assign conv_data[0] = conv_data1_i;
  assign conv_data[1] = conv_data2_i;

  // slow timer decode
  wire pre_wrap = (pre_reg == 4'(SLOW_PRESCALE - 1));
  wire slow_match = pre_wrap && (slow_cnt_reg >= slow_cmp_reg);

  // wishbone decode
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wb_wr = wb_req && wb_we_i;
  wire [31:0] status_w = {ph[0].cnt, 13'h0000, (sq_reg[0] != MPA_SQ_IDLE), armed_reg, fault_reg};
  wire [31:0] res1_w = {{(16-RES_W){1'b0}}, res_reg[0][1], {(16-RES_W){1'b0}}, res_reg[0][0]};
  wire [31:0] res2_w = {{(16-RES_W){1'b0}}, res_reg[1][1], {(16-RES_W){1'b0}}, res_reg[1][0]};
  wire [31:0] rd_mux = (wb_adr_i == ADR_CTRL) ? {28'h000_0000, ctrl_reg} :
                       (wb_adr_i == ADR_SKIP) ? {24'h00_0000, skip_reg} :
                       (wb_adr_i == ADR_INIT) ? {16'h0000, init_reg} :
                       (wb_adr_i == ADR_PERIOD) ? {16'h0000, period_reg} :
                       (wb_adr_i == ADR_TRIG) ? {16'h0000, trig_reg} :
                       (wb_adr_i == ADR_DEAD) ? {16'h0000, dead_reg} :
                       (wb_adr_i == ADR_DUTY0) ? {16'h0000, duty_reg[0]} :
                       (wb_adr_i == ADR_DUTY1) ? {16'h0000, duty_reg[1]} :
                       (wb_adr_i == ADR_DUTY2) ? {16'h0000, duty_reg[2]} :
                       (wb_adr_i == ADR_SLOW) ? {16'h0000, slow_cmp_reg} :
                       (wb_adr_i == ADR_CHAIN) ? {16'h0000, chain_reg} :
                       (wb_adr_i == ADR_STATUS) ? status_w :
                       (wb_adr_i == ADR_RES1) ? res1_w :
                       (wb_adr_i == ADR_RES2) ? res2_w : 32'h0000_0000;

  // bus ack and read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= wb_req;
      if (wb_req) begin
        rd_reg <= rd_mux;
      end
    end
  end

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      skip_reg <= SKIP_RST;
      init_reg <= INIT_RST;
      period_reg <= PERIOD_RST;
      trig_reg <= TRIG_RST;
      dead_reg <= DEAD_NS_RST;
      duty_reg <= '{DUTY_RST, DUTY_RST, DUTY_RST};
      slow_cmp_reg <= SLOW_RST;
      chain_reg <= CHAIN_RST;
    end else if (ce_i && wb_wr) begin
      case (wb_adr_i)
        ADR_CTRL: ctrl_reg <= 4'(sel_merge({28'h000_0000, ctrl_reg}, wb_dat_i, wb_sel_i));
        ADR_SKIP: skip_reg <= 8'(sel_merge({24'h00_0000, skip_reg}, wb_dat_i, wb_sel_i));
        ADR_INIT: init_reg <= 16'(sel_merge({16'h0000, init_reg}, wb_dat_i, wb_sel_i));
        ADR_PERIOD: period_reg <= 16'(sel_merge({16'h0000, period_reg}, wb_dat_i, wb_sel_i));
        ADR_TRIG: trig_reg <= 16'(sel_merge({16'h0000, trig_reg}, wb_dat_i, wb_sel_i));
        ADR_DEAD: dead_reg <= 16'(sel_merge({16'h0000, dead_reg}, wb_dat_i, wb_sel_i));
        ADR_DUTY0: duty_reg[0] <= 16'(sel_merge({16'h0000, duty_reg[0]}, wb_dat_i, wb_sel_i));
        ADR_DUTY1: duty_reg[1] <= 16'(sel_merge({16'h0000, duty_reg[1]}, wb_dat_i, wb_sel_i));
        ADR_DUTY2: duty_reg[2] <= 16'(sel_merge({16'h0000, duty_reg[2]}, wb_dat_i, wb_sel_i));
        ADR_SLOW: slow_cmp_reg <= 16'(sel_merge({16'h0000, slow_cmp_reg}, wb_dat_i, wb_sel_i));
        ADR_CHAIN: chain_reg <= 16'(sel_merge({16'h0000, chain_reg}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // duty shadows take effect only at master reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_sh_reg <= '{DUTY_RST, DUTY_RST, DUTY_RST};
    end else if (ce_i && master_reload) begin
      duty_sh_reg <= duty_reg;
    end
  end

  // reload opportunity counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_cnt_reg <= 8'h00;
    end else if (ce_i && m_wrap) begin
      skip_cnt_reg <= skip_last ? 8'h00 : 8'(skip_cnt_reg + 8'h01);
    end
  end

  // fault latch: set wins, clears at first reload with input low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else if (ce_i) begin
      if (fault_i) begin
        fault_reg <= 1'b1;
      end else if (master_reload) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // one trigger per reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
      mtrig_reg <= 1'b0;
    end else if (ce_i) begin
      mtrig_reg <= trig_hit;
      if (master_reload) begin
        armed_reg <= 1'b1;
      end else if (trig_hit) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // output register, phase a to c as hi/lo pairs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_reg <= 6'h00;
    end else if (ce_i) begin
      pwm_reg <= {ph[2].lo, ph[2].hi, ph[1].lo, ph[1].hi, ph[0].lo, ph[0].hi};
    end
  end

  // trigger chains, one per converter, two entries each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sq_reg <= '{MPA_SQ_IDLE, MPA_SQ_IDLE};
      start_reg <= 2'b00;
      chan_reg <= '{4'h0, 4'h0};
      res_reg <= '{'{'0, '0}, '{'0, '0}};
      fast_irq_reg <= 1'b0;
    end else if (ce_i) begin
      start_reg <= 2'b00;
      fast_irq_reg <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        case (sq_reg[c])
          MPA_SQ_IDLE: begin
            if (seq_in0 && active[c]) begin
              sq_reg[c] <= MPA_SQ_E0;
              start_reg[c] <= 1'b1;
              chan_reg[c] <= chain_reg[c*8 +: 4];
            end
          end
          MPA_SQ_E0: begin
            if (conv_done_i[c]) begin
              res_reg[c][0] <= conv_data[c];
              sq_reg[c] <= MPA_SQ_E1;
              start_reg[c] <= 1'b1;
              chan_reg[c] <= chain_reg[c*8+4 +: 4];
            end
          end
          MPA_SQ_E1: begin
            if (conv_done_i[c]) begin
              res_reg[c][1] <= conv_data[c];
              sq_reg[c] <= MPA_SQ_DONE;
            end
          end
          MPA_SQ_DONE: begin
            if (all_done) begin
              sq_reg[c] <= MPA_SQ_IDLE;
            end
          end
          default: sq_reg[c] <= MPA_SQ_IDLE;
        endcase
      end
      if (all_done) begin
        fast_irq_reg <= 1'b1;
      end
    end
  end

  // slow-loop timer: prescale by sixteen, count zero to compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= 4'h0;
      slow_cnt_reg <= 16'h0000;
      slow_irq_reg <= 1'b0;
    end else if (ce_i) begin
      pre_reg <= pre_wrap ? 4'h0 : 4'(pre_reg + 4'h1);
      slow_irq_reg <= slow_match;
      if (slow_match) begin
        slow_cnt_reg <= 16'h0000;
      end else if (pre_wrap) begin
        slow_cnt_reg <= 16'(slow_cnt_reg + 16'h0001);
      end
    end
  end

  // outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign pwm_o = pwm_reg;
  assign master_trigger_o = mtrig_reg;
  assign conv_start_o = start_reg;
  assign conv_chan1_o = chan_reg[0];
  assign conv_chan2_o = chan_reg[1];
  assign fast_loop_irq_o = fast_irq_reg;
  assign slow_loop_irq_o = slow_irq_reg;

endmodule // mpa_top
`default_nettype wire

// ==== mpa_pkg.sv ====
// mpa_pkg: register map, reset values and timing constants of the motor pwm block
// assumes a 100 MHz system clock and a 32-bit classic wishbone register port
package mpa_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned SLOW_PRESCALE = 16;
  localparam int unsigned SLOW_RATE_HZ = 1000;
  localparam int unsigned SLOW_CMP_CYC = CLK_HZ / (SLOW_PRESCALE * SLOW_RATE_HZ);

  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SKIP = 8'h04;
  localparam logic [7:0] ADR_INIT = 8'h08;
  localparam logic [7:0] ADR_PERIOD = 8'h0C;
  localparam logic [7:0] ADR_TRIG = 8'h10;
  localparam logic [7:0] ADR_DEAD = 8'h14;
  localparam logic [7:0] ADR_DUTY0 = 8'h18;
  localparam logic [7:0] ADR_DUTY1 = 8'h1C;
  localparam logic [7:0] ADR_DUTY2 = 8'h20;
  localparam logic [7:0] ADR_SLOW = 8'h24;
  localparam logic [7:0] ADR_CHAIN = 8'h28;
  localparam logic [7:0] ADR_STATUS = 8'h2C;
  localparam logic [7:0] ADR_RES1 = 8'h30;
  localparam logic [7:0] ADR_RES2 = 8'h34;

  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SYNC_BIT = 1;
  localparam int CTRL_XBAR_LSB = 2;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h2;
  localparam logic [7:0] SKIP_RST = 8'h01;
  localparam logic [15:0] INIT_RST = 16'hC568;
  localparam logic [15:0] PERIOD_RST = 16'h3A97;
  localparam logic [15:0] TRIG_RST = 16'h0000;
  localparam logic [15:0] DEAD_NS_RST = 16'h01F4;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] SLOW_RST = 16'(SLOW_CMP_CYC);
  localparam logic [15:0] CHAIN_RST = 16'h3210;

  // crossbar sources for sequencer input zero
  typedef enum logic [1:0] {
    MPA_XB_MASTER = 2'b00,
    MPA_XB_FOL1 = 2'b01,
    MPA_XB_FOL2 = 2'b10,
    MPA_XB_OFF = 2'b11
  } mpa_xbar_t;

  // trigger chain states
  typedef enum logic [1:0] {
    MPA_SQ_IDLE = 2'b00,
    MPA_SQ_E0 = 2'b01,
    MPA_SQ_E1 = 2'b10,
    MPA_SQ_DONE = 2'b11
  } mpa_seq_t;

endpackage

// ==== mpa_phase_if.sv ====
// mpa_phase_if: signals between the pwm top and one phase submodule
// assumes one instance per phase, all on the system clock
`timescale 1ns/1ps
`default_nettype none
interface mpa_phase_if #(parameter int W = 16);
  logic cnt_en;
  logic sync;
  logic out_en;
  logic signed [W-1:0] init;
  logic signed [W-1:0] period;
  logic signed [W-1:0] duty;
  logic [W-1:0] dt_cycles;
  logic signed [W-1:0] cnt;
  logic wrap;
  logic tick;
  logic hi;
  logic lo;
  modport ctl (output cnt_en, sync, out_en, init, period, duty, dt_cycles, input cnt, wrap, tick, hi, lo);
  modport sub (input cnt_en, sync, out_en, init, period, duty, dt_cycles, output cnt, wrap, tick, hi, lo);
endinterface
`default_nettype wire

// ==== mpa_phase.sv ====
// mpa_phase: one pwm submodule, signed counter plus complementary pair with dead time
// assumes config inputs are stable between reloads and rst_i is synchronous
`timescale 1ns/1ps
`default_nettype none
module mpa_phase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  mpa_phase_if.sub pif
);
  import mpa_pkg::*;

  logic signed [15:0] cnt_reg;
  logic raw_q_reg;
  logic [15:0] dt_cnt_reg;
  logic hi_reg;
  logic lo_reg;

  // compare decode, centred window around zero
  wire at_period = (cnt_reg == pif.period);
  wire signed [16:0] cnt_x = {cnt_reg[15], cnt_reg};
  wire signed [16:0] duty_x = {pif.duty[15], pif.duty};
  wire signed [16:0] neg_duty = 17'(-duty_x);
  wire raw = (cnt_x >= neg_duty) && (cnt_x < duty_x);
  wire dt_idle = (dt_cnt_reg == 16'h0000);

  assign pif.cnt = cnt_reg;
  assign pif.tick = pif.cnt_en; // counter clock handed on to followers
  assign pif.wrap = at_period && pif.cnt_en;
  assign pif.hi = hi_reg;
  assign pif.lo = lo_reg;

  // counter: wrap to start after period, forced to start on sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= signed'(INIT_RST);
    end else if (ce_i && pif.cnt_en) begin
      if (pif.sync || at_period) begin
        cnt_reg <= pif.init;
      end else begin
        cnt_reg <= 16'(cnt_reg + 16'sh0001);
      end
    end
  end

  // dead time: any edge of the raw level blanks both outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_q_reg <= 1'b0;
      dt_cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (raw != raw_q_reg) begin
        raw_q_reg <= raw;
        dt_cnt_reg <= pif.dt_cycles;
      end else if (!dt_idle) begin
        dt_cnt_reg <= 16'(dt_cnt_reg - 16'h0001);
      end
    end
  end

  // registered complementary outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
    end else if (ce_i) begin
      hi_reg <= pif.out_en && raw_q_reg && dt_idle;
      lo_reg <= pif.out_en && !raw_q_reg && dt_idle;
    end
  end

endmodule // mpa_phase
`default_nettype wire

// ==== mpa_top_chk.sv ====
// mpa_top_chk: timing checks on the pins of mpa_top
// assumes bench holds ce_i high; bound into every mpa_top
`timescale 1ns/1ps
`default_nettype none
module mpa_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic fault_i,
  input wire logic [5:0] pwm_o,
  input wire logic [1:0] conv_start_o,
  input wire logic [1:0] conv_done_i,
  input wire logic fast_loop_irq_o,
  input wire logic slow_loop_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // gate pair, fault blanking and bus answer
  chk_pair_not_both: assert property (!(pwm_o[0] && pwm_o[1]) && !(pwm_o[2] && pwm_o[3]) && !(pwm_o[4] && pwm_o[5]))
    else $error("both switches of a pair on");
  chk_fault_blanks: assert property (fault_i |-> ##2 pwm_o == 6'h00)
    else $error("outputs live during fault");
  chk_no_early_restart: assert property ($rose(|pwm_o) |-> !$past(fault_i, 2))
    else $error("outputs restarted with fault high");
  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a one-cycle pulse");
  // converter chains and loop interrupts
  chk_irq_after_done: assert property (fast_loop_irq_o |-> $past(|conv_done_i, 2))
    else $error("fast interrupt without a finished conversion");
  chk_second_start: assert property (conv_start_o[1] |-> conv_start_o[0] || $past(conv_done_i[1]))
    else $error("second converter started on its own");
  chk_start_pulse: assert property (conv_start_o[0] |=> !conv_start_o[0])
    else $error("start held longer than one cycle");
  chk_slow_spacing: assert property (slow_loop_irq_o |=> !slow_loop_irq_o [*8])
    else $error("slow interrupts too close");
endmodule // mpa_top_chk

bind mpa_top mpa_top_chk mpa_top_chk_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .fault_i,
  .pwm_o, .conv_start_o, .conv_done_i, .fast_loop_irq_o, .slow_loop_irq_o);
`default_nettype wire

// ==== mpa_conv_model.sv ====
// mpa_conv_model: two converters answering start pulses after lat_i+1 cycles
// assumes one start at a time per converter; result names its channel
`timescale 1ns/1ps
`default_nettype none
module mpa_conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] start_i,
  input wire logic [3:0] chan1_i,
  input wire logic [3:0] chan2_i,
  input wire logic [7:0] lat_i,
  output logic [1:0] done_o,
  output logic [11:0] data1_o,
  output logic [11:0] data2_o
);
  logic [7:0] cnt [2];
  logic [3:0] ch [2];
  // hardware-started conversion, one done pulse each
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      done_o[k] <= 1'b0;
      if (rst_i) begin
        cnt[k] <= 8'h00;
      end else if (start_i[k]) begin
        cnt[k] <= lat_i + 8'h01;
        ch[k] <= (k == 0) ? chan1_i : chan2_i;
      end else if (cnt[k] == 8'h01) begin
        cnt[k] <= 8'h00;
        done_o[k] <= 1'b1;
      end else if (cnt[k] != 8'h00) begin
        cnt[k] <= cnt[k] - 8'h01;
      end
    end
  end
  // 12-bit results, inverted outside the done cycle
  assign data1_o = done_o[0] ? {8'hA5, ch[0]} : ~{8'hA5, ch[0]};
  assign data2_o = done_o[1] ? {8'h3C, ch[1]} : ~{8'h3C, ch[1]};
endmodule // mpa_conv_model
`default_nettype wire

// ==== test_mpa_top.sv ====
// test_mpa_top: self-checking bench for mpa_top with converter model
// assumes mpa_pkg, mpa_top, mpa_top_chk and mpa_conv_model compiled first
`timescale 1ns/1ps
`default_nettype none
module test_mpa_top;
  import mpa_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] v;} mpa_note_t;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fault_i;
  logic master_trigger_o, fast_loop_irq_o, slow_loop_irq_o;
  logic [7:0] wb_adr_i, lat;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0] pwm_o;
  logic [1:0] conv_start_o, conv_done_i;
  logic [3:0] conv_chan1_o, conv_chan2_o, wb_sel_i, sel;
  logic [11:0] conv_data1_i, conv_data2_i;
  int err_total, n_tests, cyc, t_trig, t_slow, trig_gap, slow_gap, n_st0, n_st1, n_fast;
  int acc [6];
  int win [6];
  mpa_note_t notes [$];

  mpa_top mpa_top_i (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .fault_i, .pwm_o, .master_trigger_o, .conv_start_o, .conv_chan1_o,
    .conv_chan2_o, .conv_done_i, .conv_data1_i, .conv_data2_i, .fast_loop_irq_o, .slow_loop_irq_o);
  mpa_conv_model mpa_conv_model_i (.clk_i, .rst_i, .start_i(conv_start_o), .chan1_i(conv_chan1_o),
    .chan2_i(conv_chan2_o), .lat_i(lat), .done_o(conv_done_i), .data1_o(conv_data1_i), .data2_o(conv_data2_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic results();
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{a, e});
    wb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic trig(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (master_trigger_o !== 1'b1) @(posedge clk_i);
    end
    @(posedge clk_i);
  endtask

  // two reload windows: spacing, starts, interrupts and phase C on-times
  task automatic measure(input int gap, input int st1, input int hi, input int lo);
    int a0, a1, af;
    trig(3);
    a0 = n_st0;
    a1 = n_st1;
    af = n_fast;
    trig(2);
    chk_val("trigger gap", gap, trig_gap);
    chk_val("conv1 starts", 4, n_st0 - a0);
    chk_val("conv2 starts", st1, n_st1 - a1);
    chk_val("fast irqs", 2, n_fast - af);
    chk_val("c hi time", hi, win[4]);
    chk_val("c lo time", lo, win[5]);
    chk_val("a hi time", 18 * gap / 40, win[0]);
    chk_val("b lo time", 28 * gap / 40, win[3]);
    chk_val("slow gap", 80, slow_gap);
  endtask

  // event counters, per-window on-times and the hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    n_st0 <= n_st0 + int'(conv_start_o[0]);
    n_st1 <= n_st1 + int'(conv_start_o[1]);
    n_fast <= n_fast + int'(fast_loop_irq_o);
    if (master_trigger_o === 1'b1) begin
      trig_gap <= cyc - t_trig;
      t_trig <= cyc;
      win <= acc;
      foreach (acc[k]) acc[k] <= int'(pwm_o[k]);
    end else begin
      foreach (acc[k]) acc[k] <= acc[k] + int'(pwm_o[k]);
    end
    if (slow_loop_irq_o === 1'b1) begin
      slow_gap <= cyc - t_slow;
      t_slow <= cyc;
    end
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // read answers against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      chk_val($sformatf("reg %h", notes[0].a), notes[0].v, wb_dat_o);
      void'(notes.pop_front());
    end
  end

  initial begin
    logic [31:0] r;
    int a;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    sel = 4'hf;
    fault_i = 1'b0;
    lat = 8'h02;
    r = $urandom(32'hddbd);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_CTRL, 32'h0000_0002);
    rd(ADR_SKIP, 32'h0000_0001);
    rd(ADR_INIT, 32'h0000_C568);
    rd(ADR_PERIOD, 32'h0000_3A97);
    rd(ADR_DEAD, 32'h0000_01F4);
    rd(ADR_SLOW, 32'h0000_186A);
    rd(ADR_CHAIN, 32'h0000_3210);
    r = $urandom;
    wr(8'h3C, r);
    rd(8'h3C, 32'h0000_0000);
    wr(ADR_DUTY1, r);
    rd(ADR_DUTY1, {16'h0000, r[15:0]});
    // byte lane 1 only: lane 0 keeps its random value
    sel = 4'h2;
    wr(ADR_DUTY1, 32'h0000_0000);
    sel = 4'hf;
    rd(ADR_DUTY1, {24'h00_0000, r[7:0]});
    // 40-cycle period, 2-cycle dead time, reload every second wrap
    wr(ADR_INIT, 32'h0000_FFEC);
    wr(ADR_PERIOD, 32'h0000_0013);
    wr(ADR_DEAD, 32'h0000_0014);
    wr(ADR_DUTY0, 32'h0000_000A);
    wr(ADR_DUTY1, 32'h0000_0005);
    wr(ADR_DUTY2, 32'h0000_000F);
    wr(ADR_SKIP, 32'h0000_0002);
    wr(ADR_SLOW, 32'h0000_0004);
    wr(ADR_CTRL, 32'h0000_0003);
    measure(80, 4, 56, 16);
    rd(ADR_RES1, 32'h0A51_0A50);
    rd(ADR_RES2, 32'h03C3_03C2);
    // fault just after a trigger, next reload still far off
    trig(1);
    // master count three cycles past trigger point 0 + 2/2, chain 1 busy
    rd(ADR_STATUS, 32'h0004_0004);
    fault_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    fault_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk_val("outputs after fault", 32'h0000_0000, {26'h0, pwm_o});
    lat <= 8'h1E;
    measure(80, 4, 56, 16);
    lat <= 8'h02;
    wr(ADR_SKIP, 32'h0000_0001);
    measure(40, 4, 28, 8);
    wr(ADR_CTRL, 32'h0000_0001);
    measure(40, 0, 28, 8);
    // crossbar off: triggers go on, no conversion starts
    wr(ADR_CTRL, 32'h0000_000D);
    trig(1);
    a = n_st0;
    trig(2);
    chk_val("starts crossbar off", 0, n_st0 - a);
    results();
  end
endmodule // test_mpa_top
`default_nettype wire
